/* File: hdl/twi_link_sampler.sv */
// bit sampler running on the bus clock itself
// assumes the bus clock is quiet while reset is applied
`timescale 1ns/1ns
module twi_link_sampler (
  // link side
  input wire logic i_scl,
  input wire logic i_sda,
  // reset
  input wire logic i_rst,
  // towards the system domain
  output logic o_bit,
  output logic o_tgl
);

  typedef struct packed {
    logic bit_v;
    logic tgl;
  } link_t;

  link_t st;
  link_t nx;

  ////////////////////////////////////////////////////////////////////////
  // each rising bus clock edge latches the data line and flips the toggle;
  // the bit then stays put for a whole clock period, long enough to cross
  always_comb
  begin
    nx.bit_v = i_sda;
    nx.tgl = ~st.tgl;
  end

  // asynchronous clear: the bus clock stands still during reset
  always_ff @(posedge i_scl or posedge i_rst)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= nx;
  end

  assign o_bit = st.bit_v;
  assign o_tgl = st.tgl;

endmodule // twi_link_sampler

/* File: hdl/twi_slave_pkg.sv */
// constants and types shared by the two-wire control slave files
// assumes a 100 MHz system clock and a fast-mode bus master
package twi_slave_pkg;

  // system clock and bus timing
  localparam int SYS_CLK_MHZ = 100;
  localparam int SCL_MAX_KHZ = 400;
  localparam int T_HIGH_MIN_NS = 600;
  localparam int HIGH_MIN_CYC = (T_HIGH_MIN_NS * SYS_CLK_MHZ + 999) / 1000;

  // register window
  localparam logic [7:0] REG_FIRST = 8'h40;
  localparam logic [7:0] REG_LAST = 8'h4F;
  localparam int REG_COUNT = 16;
  localparam int IDX_LSB_W = 4;
  localparam logic [7:0] REG_CTRL_RST = 8'hC0;
  localparam logic [7:0] REG_OTHER_RST = 8'h00;

  // address byte layout
  localparam int ADDR_PREFIX_W = 5;
  localparam logic RW_READ = 1'h1;
  localparam logic ACK_LVL = 1'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // the strap synchroniser is cleared by reset, so it holds the pin value
  // only after two edges; the capture happens on the third
  localparam logic [1:0] MODE_SETTLE = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REG,
    ST_WDATA,
    ST_ACK,
    ST_TX,
    ST_TXACK,
    ST_TXLD,
    ST_WAIT
  } fsm_t;

endpackage

/* File: hdl/two_wire_control_slave.sv */
// two-wire control port slave with a 16-entry register window
// assumes an external master on open-drain lines with pull-ups
//
// Functional notes
// - slave only; works for bus clocks up to 400 kHz fast mode.
// - 7-bit slave address, upper five bits fixed prefix.
// - lowest two address bits come from the two address-select pins.
// - respond only to our own address; otherwise stay off the bus.
// - direction bit 1 means read, 0 means write.
// - ninth clock: low is acknowledge, high is not-acknowledge.
// - each good data byte stored at index, then index advances.
// - index past 0x4F wraps to 0x40.
// - no acknowledge for undefined register addresses.
// - register and data bytes are 8 bits, most significant first.
// - repeated start, read address, ack, indexed byte, master nack.
// - mode pin sampled at reset release; port on only when low.
`timescale 1ns/1ns
module two_wire_control_slave #(
  // arbitrary value
  parameter logic [twi_slave_pkg::ADDR_PREFIX_W-1:0] ADDR_PREFIX = 5'h0A
) (
  // system
  input wire logic i_clk,
  input wire logic i_rst,
  // bus clock and data line
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // strap pins
  input wire logic i_addr_select_low,
  input wire logic i_addr_select_high,
  input wire logic i_ctrl_mode,
  // port enable and register write notification
  output logic o_port_en,
  output logic o_wr_stb,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data
);
  import twi_slave_pkg::*;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic tgl_m;
    logic tgl_s;
    logic tgl_d;
    logic seen;
    logic bit_m;
    logic bit_s;
    logic mode_m;
    logic mode_s;
    logic a0_m;
    logic a0_s;
    logic a1_m;
    logic a1_s;
    logic [1:0] cap_cnt;
    logic en;
    fsm_t fsm;
    fsm_t ack_next;
    logic ack_drv;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [7:0] idx;
    logic [REG_COUNT-1:0][7:0] regs;
    logic sda_out;
    logic sda_oe;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } state_t;

  state_t st;
  state_t nx;

  logic link_bit;
  logic link_tgl;
  logic fall;
  logic start;
  logic stop;
  logic bit_ev;
  logic bit_v;
  logic last_bit;
  logic [7:0] rx_byte;
  logic [6:0] own_addr;
  logic addr_hit;
  logic reg_hit;
  logic idx_hit;
  logic [7:0] idx_next;
  logic load_tx;

  ////////////////////////////////////////////////////////////////////////
  // link-clock sampler

  twi_link_sampler u_sampler (
    .i_scl (i_scl),
    .i_sda (i_sda_in),
    .i_rst (i_rst),
    .o_bit (link_bit),
    .o_tgl (link_tgl)
  );

  ////////////////////////////////////////////////////////////////////////
  // decoded events

  assign fall = st.scl_p & ~st.scl_s;
  assign start = st.scl_s & st.scl_p & st.sda_p & ~st.sda_s;
  assign stop = st.scl_s & st.scl_p & ~st.sda_p & st.sda_s;
  // toggle runs one stage behind the bit so the bit has surely settled
  assign bit_ev = st.tgl_d != st.seen;
  assign bit_v = st.bit_s;
  assign last_bit = st.cnt == BIT_LAST;
  assign rx_byte = {st.sh[6:0], bit_v};
  assign own_addr = {ADDR_PREFIX, st.a1_s, st.a0_s};
  assign addr_hit = rx_byte[7:1] == own_addr;
  assign reg_hit = (rx_byte >= REG_FIRST) && (rx_byte <= REG_LAST);
  assign idx_hit = (st.idx >= REG_FIRST) && (st.idx <= REG_LAST);
  assign idx_next = (st.idx == REG_LAST) ? REG_FIRST : st.idx + 8'h01;
  assign load_tx = fall && ((st.fsm == ST_TXLD) ||
                   (st.fsm == ST_ACK && st.ack_drv && st.ack_next == ST_TX));

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    nx = st;
    nx.scl_m = i_scl;
    nx.scl_s = st.scl_m;
    nx.scl_p = st.scl_s;
    nx.sda_m = i_sda_in;
    nx.sda_s = st.sda_m;
    nx.sda_p = st.sda_s;
    nx.tgl_m = link_tgl;
    nx.tgl_s = st.tgl_m;
    nx.tgl_d = st.tgl_s;
    nx.seen = st.tgl_d;
    nx.bit_m = link_bit;
    nx.bit_s = st.bit_m;
    nx.mode_m = i_ctrl_mode;
    nx.mode_s = st.mode_m;
    nx.a0_m = i_addr_select_low;
    nx.a0_s = st.a0_m;
    nx.a1_m = i_addr_select_high;
    nx.a1_s = st.a1_m;
    nx.sda_out = 1'h0;
    nx.wr_stb = 1'h0;
    // mode strap is caught once, after the synchroniser has filled
    if (st.cap_cnt != MODE_SETTLE)
    begin
      nx.cap_cnt = st.cap_cnt + 2'h1;
      if (st.cap_cnt + 2'h1 == MODE_SETTLE)
        nx.en = ~st.mode_s;
    end
    if (!st.en)
    begin
      nx.fsm = ST_IDLE;
      nx.sda_oe = 1'h0;
    end
    else if (start)
    begin
      nx.fsm = ST_ADDR;
      nx.cnt = 3'h0;
      nx.sda_oe = 1'h0;
    end
    else if (stop)
    begin
      nx.fsm = ST_IDLE;
      nx.sda_oe = 1'h0;
    end
    else
    begin
      case (st.fsm)
        ST_ADDR:
        begin
          if (bit_ev)
          begin
            nx.sh = rx_byte;
            nx.cnt = st.cnt + 3'h1;
            if (last_bit)
            begin
              if (addr_hit)
              begin
                nx.rw = bit_v;
                nx.ack_drv = 1'h0;
                nx.fsm = ST_ACK;
                nx.ack_next = (bit_v == RW_READ) ? ST_TX : ST_REG;
              end
              else
                nx.fsm = ST_WAIT;
            end
          end
        end
        ST_REG:
        begin
          if (bit_ev)
          begin
            nx.sh = rx_byte;
            nx.cnt = st.cnt + 3'h1;
            if (last_bit)
            begin
              if (reg_hit)
              begin
                nx.idx = rx_byte;
                nx.ack_drv = 1'h0;
                nx.fsm = ST_ACK;
                nx.ack_next = ST_WDATA;
              end
              else
                nx.fsm = ST_WAIT;
            end
          end
        end
        ST_WDATA:
        begin
          if (bit_ev)
          begin
            nx.sh = rx_byte;
            nx.cnt = st.cnt + 3'h1;
            if (last_bit)
            begin
              if (idx_hit)
              begin
                nx.regs[st.idx[IDX_LSB_W-1:0]] = rx_byte;
                nx.wr_stb = 1'h1;
                nx.wr_addr = st.idx;
                nx.wr_data = rx_byte;
                nx.idx = idx_next;
                nx.ack_drv = 1'h0;
                nx.fsm = ST_ACK;
                nx.ack_next = ST_WDATA;
              end
              else
                nx.fsm = ST_WAIT;
            end
          end
        end
        ST_ACK:
        begin
          if (fall)
          begin
            if (!st.ack_drv)
            begin
              nx.sda_oe = 1'h1;
              nx.ack_drv = 1'h1;
            end
            else
            begin
              nx.sda_oe = 1'h0;
              nx.cnt = 3'h0;
              nx.fsm = st.ack_next;
            end
          end
        end
        ST_TX:
        begin
          if (fall)
          begin
            if (last_bit)
            begin
              nx.sda_oe = 1'h0;
              nx.fsm = ST_TXACK;
            end
            else
            begin
              nx.sda_oe = ~st.sh[6];
              nx.sh = {st.sh[6:0], 1'h0};
              nx.cnt = st.cnt + 3'h1;
            end
          end
        end
        ST_TXACK:
        begin
          if (bit_ev)
            nx.fsm = (bit_v == ACK_LVL) ? ST_TXLD : ST_WAIT;
        end
        ST_IDLE, ST_WAIT, ST_TXLD:
        begin
          nx.sda_oe = 1'h0;
        end
        default:
        begin
          nx.fsm = ST_IDLE;
          nx.sda_oe = 1'h0;
        end
      endcase
      // first read bit goes out on the same falling edge that ends the ack
      if (load_tx)
      begin
        nx.sh = st.regs[st.idx[IDX_LSB_W-1:0]];
        nx.sda_oe = ~st.regs[st.idx[IDX_LSB_W-1:0]][7];
        nx.cnt = 3'h0;
        nx.idx = idx_next;
        nx.fsm = ST_TX;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; idle bus lines are high, so the clock and data line samplers start high

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st <= '0;
      st.scl_m <= 1'h1;
      st.scl_s <= 1'h1;
      st.scl_p <= 1'h1;
      st.sda_m <= 1'h1;
      st.sda_s <= 1'h1;
      st.sda_p <= 1'h1;
      st.idx <= REG_FIRST;
      st.regs <= {REG_COUNT{REG_OTHER_RST}};
      st.regs[0] <= REG_CTRL_RST;
    end
    else
      st <= nx;
  end

  assign o_sda_out = st.sda_out;
  assign o_sda_oe = st.sda_oe;
  assign o_port_en = st.en;
  assign o_wr_stb = st.wr_stb;
  assign o_wr_addr = st.wr_addr;
  assign o_wr_data = st.wr_data;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_addr_done;
    st.en && !start && !stop && st.fsm == ST_ADDR && bit_ev && last_bit;
  endsequence

  sequence s_ack_begin;
    st.en && !start && !stop && st.fsm == ST_ACK && fall && !st.ack_drv;
  endsequence

  addr_match_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_addr_done |->
      if (addr_hit) ##1 st.fsm == ST_ACK else ##1 st.fsm == ST_WAIT)
    else $error("address match decision wrong");

  addr_pins_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_addr_done and (rx_byte[2:1] != {st.a1_s, st.a0_s})
      |=> st.fsm == ST_WAIT && !st.sda_oe)
    else $error("foreign pin address acked");

  dir_bit_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_addr_done and addr_hit |=>
      st.rw == $past(bit_v) &&
      (st.ack_next == ST_TX) == ($past(bit_v) == RW_READ))
    else $error("direction bit misread");

  ack_hold_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_ack_begin |=> st.sda_oe [*8])
    else $error("acknowledge not held low");

  idx_step_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    nx.wr_stb && st.idx != REG_LAST |=>
      st.wr_stb && st.idx == $past(st.idx) + 8'h01 &&
      st.regs[$past(st.idx[IDX_LSB_W-1:0])] == st.wr_data)
    else $error("index did not advance");

  idx_wrap_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    nx.wr_stb && st.idx == REG_LAST |=> st.idx == REG_FIRST)
    else $error("index did not wrap");

  undef_nack_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st.en && !start && !stop && st.fsm == ST_REG && bit_ev && last_bit &&
      !reg_hit |=> st.fsm == ST_WAIT ##1 !st.sda_oe)
    else $error("undefined register acked");

  mode_gate_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st.cap_cnt == MODE_SETTLE && $past(st.cap_cnt) == MODE_SETTLE
      |-> $stable(st.en) && (st.en || (st.fsm == ST_IDLE && !st.sda_oe)))
    else $error("mode strap not honoured");

  nack_release_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st.en && !start && !stop && st.fsm == ST_TXACK && bit_ev && bit_v
      |=> !st.sda_oe && st.fsm == ST_WAIT)
    else $error("line held after nack");

  stop_idle_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st.en && stop |=> st.fsm == ST_IDLE && !st.sda_oe)
    else $error("stop did not idle");

  drive_low_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $rose(st.sda_oe) |-> !st.scl_p)
    else $error("data driven while clock high");

  tx_msb_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st.en && !start && !stop && load_tx |=>
      st.sda_oe == ~$past(st.regs[st.idx[IDX_LSB_W-1:0]][7]) &&
      st.fsm == ST_TX)
    else $error("read byte msb wrong");

endmodule // two_wire_control_slave

/* File: testbench/twi_master_model.sv */
// two-wire bus master model that drives the link for the bench
// assumes a free 64 ns tick clock and a pull-up on the data wire
`timescale 1ns/1ns
module twi_master_model (
  // tick and resolved data wire
  input wire logic i_tick,
  input wire logic i_sda,
  // bus clock and data pull-down
  output logic o_scl,
  output logic o_sda_oe
);
  // 21 ticks low, 10 high: just above the fast-mode minimum widths
  localparam int LO = 21;
  localparam int HI = 10;

  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(posedge i_tick);
  endtask

  // start, or repeated start when the bus clock is low
  task automatic start();
    if (o_scl == 1'b0)
    begin
      hold(2);
      o_sda_oe = 1'b0;
      hold(LO);
      o_scl = 1'b1;
    end
    hold(HI);
    o_sda_oe = 1'b1;
    hold(HI);
    o_scl = 1'b0;
  endtask

  task automatic stop();
    hold(2);
    o_sda_oe = 1'b1;
    hold(LO);
    o_scl = 1'b1;
    hold(HI);
    o_sda_oe = 1'b0;
    hold(LO);
  endtask

  // eight bits msb first, then the acknowledge slot; data moves
  // two ticks after the fall so the slave sees a clean hold time
  task automatic xfer(input logic [7:0] d, input logic ack_out,
                      output logic [7:0] q, output logic ack_in);
    logic [8:0] sh;
    sh = {d, ack_out};
    for (int i = 8; i >= 0; i--)
    begin
      hold(2);
      o_sda_oe = ~sh[i];
      hold(LO - 2);
      o_scl = 1'b1;
      hold(HI);
      sh[i] = i_sda;
      o_scl = 1'b0;
    end
    q = sh[8:1];
    ack_in = sh[0];
  endtask
endmodule // twi_master_model

/* File: testbench/two_wire_control_slave_tb.sv */
// self-checking bench for the two-wire control slave
// assumes the master model above and a pull-up on the data wire
`timescale 1ns/1ns
module two_wire_control_slave_tb;
  import twi_slave_pkg::*;
  // arbitrary value
  localparam logic [4:0] PFX = 5'h0A;
  localparam int LIMIT = 90000;
  logic i_clk = 1'b0;
  logic i_tick = 1'b0;
  logic i_rst = 1'b0;
  logic i_addr_select_low = 1'b0;
  logic i_addr_select_high = 1'b0;
  logic i_ctrl_mode = 1'b0;
  logic scl, m_oe, s_out, s_oe, sda, port_en, wr_stb;
  logic [7:0] wr_addr, wr_data;
  logic [7:0] mem [16];
  logic [7:0] rnd = 8'h52;
  logic [15:0] wq [$];
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  //////////////////////////////////////////////////////////////////////
  always #5 i_clk = ~i_clk;
  always #32 i_tick = ~i_tick;
  assign sda = !(m_oe || (s_oe && !s_out));

  two_wire_control_slave #(.ADDR_PREFIX(PFX)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda_in(sda),
    .o_sda_out(s_out), .o_sda_oe(s_oe),
    .i_addr_select_low(i_addr_select_low),
    .i_addr_select_high(i_addr_select_high),
    .i_ctrl_mode(i_ctrl_mode), .o_port_en(port_en), .o_wr_stb(wr_stb),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data));

  twi_master_model m (
    .i_tick(i_tick), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  always @(negedge i_clk)
    if (wr_stb === 1'b1)
      wq.push_back({wr_addr, wr_data});

  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      wrap_up();
    end
  end

  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  function automatic logic [7:0] nxt(input logic [7:0] r);
    return (r == REG_LAST) ? REG_FIRST : r + 8'h01;
  endfunction

  function automatic logic [6:0] own(input logic [1:0] k);
    return {PFX, k};
  endfunction

  task automatic byte_io(input logic [7:0] d, input logic ea,
                         output logic [7:0] q);
    logic a;
    m.xfer(d, 1'b1, q, a);
    check(ea, a);
  endtask

  task automatic begin_frame(input logic [6:0] sa, input logic rw,
                             input logic ea);
    logic [7:0] q;
    m.start();
    byte_io({sa, rw}, ea, q);
  endtask

  task automatic probe(input logic [6:0] sa, input logic ea);
    begin_frame(sa, 1'b0, ea);
    m.stop();
  endtask

  task automatic wr(input logic [6:0] sa, input logic [7:0] r,
                    input int n, input logic ea);
    logic [7:0] q, d;
    begin_frame(sa, 1'b0, ACK_LVL);
    byte_io(r, ea, q);
    for (int i = 0; i < n; i++)
    begin
      rnd = lfsr(rnd);
      d = rnd;
      byte_io(d, ACK_LVL, q);
      check({r, d}, wq.pop_front());
      mem[r[3:0]] = d;
      r = nxt(r);
    end
    m.stop();
  endtask

  task automatic rd(input logic [6:0] sa, input logic [7:0] r,
                    input int n);
    logic [7:0] q;
    logic a;
    begin_frame(sa, 1'b0, ACK_LVL);
    byte_io(r, ACK_LVL, q);
    begin_frame(sa, RW_READ, ACK_LVL);
    for (int i = 0; i < n; i++)
    begin
      m.xfer(8'hFF, i == n - 1, q, a);
      check(mem[r[3:0]], q);
      r = nxt(r);
    end
    repeat (10) @(negedge i_clk);
    check(1'b0, s_oe);
    m.stop();
  endtask

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    // reset rises after time zero so the bus-clock sampler sees an edge
    #1 i_rst = 1'b1;
    for (int i = 0; i < 16; i++)
      mem[i] = (i == 0) ? REG_CTRL_RST : REG_OTHER_RST;
    repeat (16) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_clk);
    check(1'b1, port_en);
    rd(own(2'h0), REG_FIRST, 1);
    wr(own(2'h0), 8'h4E, 3, ACK_LVL);
    rd(own(2'h0), REG_LAST, 2);
    wr(own(2'h0), 8'h50, 0, ~ACK_LVL);
    wr(own(2'h0), 8'h3F, 0, ~ACK_LVL);
    check(16'h0000, 16'(wq.size()));
    for (int k = 0; k < 4; k++)
    begin
      @(negedge i_clk);
      {i_addr_select_high, i_addr_select_low} = 2'(k);
      repeat (8) @(negedge i_clk);
      probe(own(2'(k)), ACK_LVL);
      probe(own(2'(k ^ 1)), ~ACK_LVL);
    end
    // second reset with the strap high turns the port off
    @(negedge i_clk);
    i_rst = 1'b1;
    i_ctrl_mode = 1'b1;
    repeat (16) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_clk);
    check(1'b0, port_en);
    probe(own(2'h3), ~ACK_LVL);
    wrap_up();
  end
endmodule // two_wire_control_slave_tb
